// ===== inc/cpu_core_pkg.sv
/*
  Constants, enumerations and carrier structs for the core-side register
  file, flag word and stack pointer block.
  Assumes a single core clock and an instruction decoder on that clock.
*/
// Functional notes
// RULE_01 - Flag bit 5 is half carry, out of the low nibble.
// RULE_02 - Flag bit 4 always equals negative XOR overflow.
// RULE_03 - Flag bit 3 is the two's complement overflow of signed arithmetic.
// RULE_04 - Flag bit 2 is set on a negative result.
// RULE_05 - Flag bit 1 is set on a zero result; SBC sets it only if it was already set.
// RULE_06 - Flag bit 0 is set on a carry.
// RULE_07 - File serves 8/8, 8+8/8, 8+8/16 and 16/16 read/write schemes.
// RULE_08 - All 32 registers also appear at the lowest 32 data addresses.
// RULE_09 - Registers 26/27, 28/29, 30/31 form pointer pairs A, B, C.
// RULE_10 - Pointer pairs offer displacement, post-increment and pre-decrement.
// RULE_11 - Stack grows down: push minus one, pop plus one.
// RULE_12 - Call or interrupt entry minus two; returns plus two.
// RULE_13 - Stack pointer bytes at I/O 0x3E/0x3D, read/write, reset to top.
// RULE_14 - Software sets stack pointer above 0x0100 before calls or interrupts.
// RULE_15 - Core runs straight on the core clock, no divider.
// RULE_16 - Next instruction fetched while current executes, one per clock.
// RULE_17 - Two-operand ALU read, compute and write back in one clock.
// RULE_18 - Flag bit 7 is global interrupt enable, cleared on entry, set on exit.
// RULE_19 - Flag bit 6 is the bit store / bit load storage bit.
// RULE_20 - Flags an operation does not define keep their old value.
package cpu_core_pkg;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0]  FLAG_RESET      = 8'h00;
  localparam logic [7:0]  MASK_NONE       = 8'h00;
  localparam logic [7:0]  MASK_HSVNZC     = 8'h3F;
  localparam logic [7:0]  MASK_SVNZ       = 8'h1E;
  localparam logic [7:0]  MASK_SVNZC      = 8'h1F;
  localparam logic [7:0]  MASK_ZC         = 8'h03;
  localparam logic [7:0]  MASK_T          = 8'h40;
  localparam logic [7:0]  MASK_I          = 8'h80;

  localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'h02FF;
  localparam logic [15:0] DS_IO_BASE      = 16'h0020;
  localparam logic [15:0] DS_IO_END       = 16'h005F;
  localparam logic [5:0]  IO_SP_LOW       = 6'h3D;
  localparam logic [5:0]  IO_SP_HIGH      = 6'h3E;
  localparam logic [5:0]  IO_FLAG_WORD    = 6'h3F;

  localparam logic [4:0]  PAIR_A_LO       = 5'h1A;
  localparam logic [4:0]  PAIR_B_LO       = 5'h1C;
  localparam logic [4:0]  PAIR_C_LO       = 5'h1E;
  localparam logic [4:0]  MUL_DST         = 5'h00;
  localparam logic [15:0] STEP_ONE        = 16'h0001;
  localparam logic [15:0] STEP_TWO        = 16'h0002;
  localparam logic [7:0]  VAL_MIN_NEG     = 8'h80;
  localparam logic [7:0]  VAL_MAX_POS     = 8'h7F;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR,
    OP_MOV, OP_LDI, OP_INC, OP_DEC, OP_COM, OP_ADIW, OP_SBIW, OP_MUL,
    OP_MOVW, OP_BST, OP_BLD, OP_FSET, OP_FCLR, OP_PUSH, OP_POP,
    OP_CALL, OP_RET, OP_IRQ, OP_INTERRUPT_EXIT_OP, OP_PTR_DISP, OP_PTR_INC,
    OP_PTR_DEC
  } op_t;

  typedef struct packed {
    op_t        op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
    logic [2:0] bsel;
  } cmd_t;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;
endpackage : cpu_core_pkg

// ===== logic/cpu_regfile_flags_stack.sv
/*
  Register file, flag word, pointer pairs and stack pointer of the core.
  Assumes the decoder issues one command per core clock and that the
  data-space port comes from logic on the same clock.
*/
`timescale 1ns/1ps
module cpu_regfile_flags_stack
  import cpu_core_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire cmd_t        cmd_i,
  input  wire mem_req_t    mem_i,
  output logic [7:0]       flag_word_o,
  output logic [15:0]      stack_ptr_o,
  output logic [15:0]      ptr_addr_o,
  output logic [7:0]       mem_rdata_o,
  output logic             mem_hit_o
);

  logic [7:0]  rf_ff [32];
  logic [7:0]  flag_ff;
  logic [15:0] sp_ff;
  logic [15:0] ptr_addr_ff;
  logic [7:0]  rdata_ff;
  logic        hit_ff;

  // Data-space decode, shared by read and write paths
  function automatic logic is_reg(input logic [15:0] a);
    return a < DS_IO_BASE;
  endfunction : is_reg

  function automatic logic is_io(input logic [15:0] a, input logic [5:0] o);
    return (a >= DS_IO_BASE) && (a <= DS_IO_END)
      && (6'(a - DS_IO_BASE) == o);
  endfunction : is_io

  // Operands
  wire logic [7:0]  opa      = rf_ff[cmd_i.dst];
  wire logic [7:0]  opb      = rf_ff[cmd_i.src];
  wire logic [4:0]  dst_even = {cmd_i.dst[4:1], 1'b0};
  wire logic [4:0]  src_even = {cmd_i.src[4:1], 1'b0};
  wire logic [15:0] opw      = {rf_ff[dst_even | 5'h01], rf_ff[dst_even]};
  wire logic [15:0] srcw     = {rf_ff[src_even | 5'h01], rf_ff[src_even]};
  wire logic        cin      = flag_ff[FLAG_C];

  // Pointer pair selection
  wire logic [4:0]  ptr_lo = (cmd_i.bsel[1:0] == 2'h0) ? PAIR_A_LO :
                             (cmd_i.bsel[1:0] == 2'h1) ? PAIR_B_LO :
                             PAIR_C_LO; // [RULE_09]
  wire logic [15:0] ptr_val = {rf_ff[ptr_lo | 5'h01], rf_ff[ptr_lo]};

  logic [7:0]  res8;
  logic [15:0] res16;
  logic        wr_lo;
  logic        wr_hi;
  logic [4:0]  wr_idx;
  logic [7:0]  fmask;
  logic [7:0]  fnew;
  logic [15:0] nxt_sp;
  logic        sp_upd;
  logic [15:0] nxt_ptr_addr;
  logic [8:0]  sum9;
  logic [15:0] prod;

  always_comb begin
    res8         = 8'h00;
    res16        = 16'h0000;
    wr_lo        = 1'b0;
    wr_hi        = 1'b0;
    wr_idx       = cmd_i.dst;
    fmask        = MASK_NONE;
    fnew         = flag_ff;
    nxt_sp       = sp_ff;
    sp_upd       = 1'b0;
    nxt_ptr_addr = ptr_addr_ff;
    sum9         = 9'h000;
    prod         = 16'h0000;
    case (cmd_i.op)
      OP_ADD, OP_ADC: begin // [RULE_17]
        sum9  = {1'b0, opa} + {1'b0, opb}
              + {8'h00, (cmd_i.op == OP_ADC) & cin};
        res8  = sum9[7:0];
        wr_lo = 1'b1;
        fmask = MASK_HSVNZC;
        fnew[FLAG_H] = (opa[3] & opb[3]) | (opb[3] & ~res8[3])
                     | (~res8[3] & opa[3]); // [RULE_01]
        fnew[FLAG_V] = (opa[7] & opb[7] & ~res8[7])
                     | (~opa[7] & ~opb[7] & res8[7]); // [RULE_03]
        fnew[FLAG_C] = sum9[8]; // [RULE_06]
        fnew[FLAG_Z] = (res8 == 8'h00); // [RULE_05]
      end
      OP_SUB, OP_SBC: begin // [RULE_17]
        sum9  = {1'b0, opa} - {1'b0, opb}
              - {8'h00, (cmd_i.op == OP_SBC) & cin};
        res8  = sum9[7:0];
        wr_lo = 1'b1;
        fmask = MASK_HSVNZC;
        fnew[FLAG_H] = (~opa[3] & opb[3]) | (opb[3] & res8[3])
                     | (res8[3] & ~opa[3]); // [RULE_01]
        fnew[FLAG_V] = (opa[7] & ~opb[7] & ~res8[7])
                     | (~opa[7] & opb[7] & res8[7]); // [RULE_03]
        fnew[FLAG_C] = sum9[8]; // [RULE_06]
        fnew[FLAG_Z] = (res8 == 8'h00)
                     & ((cmd_i.op == OP_SUB) | flag_ff[FLAG_Z]); // [RULE_05]
      end
      OP_AND, OP_OR, OP_EOR: begin
        res8  = (cmd_i.op == OP_AND) ? (opa & opb) :
                (cmd_i.op == OP_OR)  ? (opa | opb) : (opa ^ opb);
        wr_lo = 1'b1;
        fmask = MASK_SVNZ;
        fnew[FLAG_V] = 1'b0; // [RULE_03]
        fnew[FLAG_Z] = (res8 == 8'h00); // [RULE_05]
      end
      OP_MOV: begin // [RULE_07]
        res8  = opb;
        wr_lo = 1'b1;
      end
      OP_LDI: begin
        res8  = cmd_i.imm;
        wr_lo = 1'b1;
      end
      OP_INC, OP_DEC: begin // [RULE_07]
        res8  = (cmd_i.op == OP_INC) ? 8'(opa + 8'h01) : 8'(opa - 8'h01);
        wr_lo = 1'b1;
        fmask = MASK_SVNZ;
        fnew[FLAG_V] = (cmd_i.op == OP_INC) ? (res8 == VAL_MIN_NEG)
                                            : (res8 == VAL_MAX_POS);
        fnew[FLAG_Z] = (res8 == 8'h00); // [RULE_05]
      end
      OP_COM: begin
        res8  = ~opa;
        wr_lo = 1'b1;
        fmask = MASK_SVNZC;
        fnew[FLAG_V] = 1'b0;
        fnew[FLAG_C] = 1'b1; // [RULE_06]
        fnew[FLAG_Z] = (res8 == 8'h00); // [RULE_05]
      end
      OP_ADIW, OP_SBIW: begin // [RULE_07]
        res16  = (cmd_i.op == OP_ADIW) ? 16'(opw + {8'h00, cmd_i.imm})
                                       : 16'(opw - {8'h00, cmd_i.imm});
        wr_idx = dst_even;
        wr_lo  = 1'b1;
        wr_hi  = 1'b1;
        fmask  = MASK_SVNZC;
        fnew[FLAG_V] = (cmd_i.op == OP_ADIW) ? (~opw[15] & res16[15])
                                             : (opw[15] & ~res16[15]);
        fnew[FLAG_C] = (cmd_i.op == OP_ADIW) ? (opw[15] & ~res16[15])
                                             : (~opw[15] & res16[15]);
        fnew[FLAG_N] = res16[15]; // [RULE_04]
        fnew[FLAG_Z] = (res16 == 16'h0000); // [RULE_05]
      end
      OP_MUL: begin // [RULE_07]
        prod   = {8'h00, opa} * {8'h00, opb};
        res16  = prod;
        wr_idx = MUL_DST;
        wr_lo  = 1'b1;
        wr_hi  = 1'b1;
        fmask  = MASK_ZC;
        fnew[FLAG_C] = prod[15]; // [RULE_06]
        fnew[FLAG_Z] = (prod == 16'h0000); // [RULE_05]
      end
      OP_MOVW: begin // [RULE_07]
        res16  = srcw;
        wr_idx = dst_even;
        wr_lo  = 1'b1;
        wr_hi  = 1'b1;
      end
      OP_BST: begin
        fmask = MASK_T;
        fnew[FLAG_T] = opa[cmd_i.bsel]; // [RULE_19]
      end
      OP_BLD: begin
        res8  = opa;
        res8[cmd_i.bsel] = flag_ff[FLAG_T]; // [RULE_19]
        wr_lo = 1'b1;
      end
      OP_FSET, OP_FCLR: begin
        fmask = 8'h01 << cmd_i.bsel;
        fnew[cmd_i.bsel] = (cmd_i.op == OP_FSET);
      end
      OP_PUSH, OP_POP: begin
        sp_upd = 1'b1;
        nxt_sp = (cmd_i.op == OP_PUSH) ? 16'(sp_ff - STEP_ONE)
                                       : 16'(sp_ff + STEP_ONE); // [RULE_11]
      end
      OP_CALL, OP_RET: begin
        sp_upd = 1'b1;
        nxt_sp = (cmd_i.op == OP_CALL) ? 16'(sp_ff - STEP_TWO)
                                       : 16'(sp_ff + STEP_TWO); // [RULE_12]
      end
      OP_IRQ: begin
        sp_upd = 1'b1;
        nxt_sp = 16'(sp_ff - STEP_TWO); // [RULE_12]
        fmask  = MASK_I;
        fnew[FLAG_I] = 1'b0; // [RULE_18]
      end
      OP_INTERRUPT_EXIT_OP: begin
        sp_upd = 1'b1;
        nxt_sp = 16'(sp_ff + STEP_TWO); // [RULE_12]
        fmask  = MASK_I;
        fnew[FLAG_I] = 1'b1; // [RULE_18]
      end
      OP_PTR_DISP: begin
        nxt_ptr_addr = 16'(ptr_val + {8'h00, cmd_i.imm}); // [RULE_10]
      end
      OP_PTR_INC: begin
        nxt_ptr_addr = ptr_val;
        res16  = 16'(ptr_val + STEP_ONE); // [RULE_10]
        wr_idx = ptr_lo;
        wr_lo  = 1'b1;
        wr_hi  = 1'b1;
      end
      OP_PTR_DEC: begin
        res16  = 16'(ptr_val - STEP_ONE); // [RULE_10]
        nxt_ptr_addr = res16;
        wr_idx = ptr_lo;
        wr_lo  = 1'b1;
        wr_hi  = 1'b1;
      end
      default: begin
        res8 = 8'h00;
      end
    endcase
    // Here only byte results feed N, and Z except for SBC; flag set/clear keeps its own value
    if (fmask[FLAG_Z] && wr_lo && !wr_hi && (cmd_i.op != OP_SBC)) begin
      fnew[FLAG_Z] = (res8 == 8'h00); // [RULE_05]
    end
    if (fmask[FLAG_N] && wr_lo && !wr_hi) begin
      fnew[FLAG_N] = res8[7]; // [RULE_04]
    end
  end

  // Byte to write into each half
  wire logic [7:0] wr_lo_data = wr_hi ? res16[7:0] : res8;
  wire logic [7:0] wr_hi_data = res16[15:8];
  wire logic [4:0] wr_hi_idx  = wr_idx | 5'h01;

  // Software writes through the data-space port
  wire logic mem_wr_reg  = mem_i.we && is_reg(mem_i.addr); // [RULE_08]
  wire logic mem_wr_spl  = mem_i.we && is_io(mem_i.addr, IO_SP_LOW);
  wire logic mem_wr_sph  = mem_i.we && is_io(mem_i.addr, IO_SP_HIGH);
  wire logic mem_wr_flag = mem_i.we && is_io(mem_i.addr, IO_FLAG_WORD);

  // Flag merge: untouched flags hold, sign kept as N xor V
  logic [7:0] merged;
  always_comb begin
    merged = mem_wr_flag ? mem_i.wdata : flag_ff;
    merged = (merged & ~fmask) | (fnew & fmask); // [RULE_20]
    merged[FLAG_S] = merged[FLAG_N] ^ merged[FLAG_V]; // [RULE_02]
  end
  wire logic [7:0] nxt_flag = merged;

  // Stack pointer: datapath adjustment wins over a software write
  wire logic [15:0] sw_sp = {mem_wr_sph ? mem_i.wdata : sp_ff[15:8],
                             mem_wr_spl ? mem_i.wdata : sp_ff[7:0]};
  wire logic [15:0] nxt_sp_final = sp_upd ? nxt_sp : sw_sp; // [RULE_13]

  // Data-space read mux
  wire logic        rd_reg  = is_reg(mem_i.addr);
  wire logic        rd_spl  = is_io(mem_i.addr, IO_SP_LOW);
  wire logic        rd_sph  = is_io(mem_i.addr, IO_SP_HIGH);
  wire logic        rd_flag = is_io(mem_i.addr, IO_FLAG_WORD);
  wire logic [7:0]  nxt_rdata =
    rd_reg  ? rf_ff[mem_i.addr[4:0]] : // [RULE_08]
    rd_spl  ? sp_ff[7:0] :
    rd_sph  ? sp_ff[15:8] :
    rd_flag ? flag_ff : 8'h00;
  wire logic nxt_hit = mem_i.re && (rd_reg || rd_spl || rd_sph || rd_flag);

  // One command taken every rising core clock edge, no divider
  always_ff @(posedge core_clk_i) begin // [RULE_15] [RULE_16]
    if (!rst_n_i) begin
      for (int i = 0; i < 32; i++) begin
        rf_ff[i] <= 8'h00;
      end
    end else begin
      if (mem_wr_reg) begin
        rf_ff[mem_i.addr[4:0]] <= mem_i.wdata; // [RULE_08]
      end
      if (wr_lo) begin
        rf_ff[wr_idx] <= wr_lo_data; // [RULE_17]
      end
      if (wr_hi) begin
        rf_ff[wr_hi_idx] <= wr_hi_data; // [RULE_07]
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flag_ff     <= FLAG_RESET;
      sp_ff       <= TOP_OF_DATA_MEMORY; // [RULE_13]
      ptr_addr_ff <= 16'h0000;
      rdata_ff    <= 8'h00;
      hit_ff      <= 1'b0;
    end else begin
      flag_ff     <= nxt_flag;
      sp_ff       <= nxt_sp_final;
      ptr_addr_ff <= nxt_ptr_addr;
      rdata_ff    <= mem_i.re ? nxt_rdata : rdata_ff;
      hit_ff      <= nxt_hit;
    end
  end

  assign flag_word_o = flag_ff;
  assign stack_ptr_o = sp_ff;
  assign ptr_addr_o  = ptr_addr_ff;
  assign mem_rdata_o = rdata_ff;
  assign mem_hit_o   = hit_ff;

endmodule : cpu_regfile_flags_stack

// ===== dv/cpu_regfile_flags_stack_chk.sv
/*
  Checker for the register file, flag and stack block ports.
  Assumes it is bound to the top module and one core clock.
*/
`timescale 1ns/1ps
module cpu_regfile_flags_stack_chk
  import cpu_core_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire cmd_t        cmd_i,
  input wire mem_req_t    mem_i,
  input wire logic [7:0]  flag_word_o,
  input wire logic [15:0] stack_ptr_o,
  input wire logic [15:0] ptr_addr_o,
  input wire logic [7:0]  mem_rdata_o,
  input wire logic        mem_hit_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire op_t cur_op;
  assign cur_op = cmd_i.op;

  property p_sign;
    flag_word_o[FLAG_S] == (flag_word_o[FLAG_N] ^ flag_word_o[FLAG_V]);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign bit differs from N xor V");
  property p_push;
    cur_op == OP_PUSH |=> stack_ptr_o == $past(stack_ptr_o) - 16'h0001;
  endproperty
  a_push: assert property (p_push)
    else $error("push did not lower stack pointer by one");
  property p_pop;
    cur_op == OP_POP |=> stack_ptr_o == $past(stack_ptr_o) + 16'h0001;
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop did not raise stack pointer by one");
  property p_call;
    cur_op inside {OP_CALL, OP_IRQ} |=>
      stack_ptr_o == $past(stack_ptr_o) - 16'h0002;
  endproperty
  a_call: assert property (p_call)
    else $error("call entry did not lower stack pointer by two");
  property p_ret;
    cur_op inside {OP_RET, OP_INTERRUPT_EXIT_OP} |=>
      stack_ptr_o == $past(stack_ptr_o) + 16'h0002;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not raise stack pointer by two");
  property p_ien;
    cur_op inside {OP_IRQ, OP_INTERRUPT_EXIT_OP} |=>
      flag_word_o[FLAG_I] == ($past(cur_op) == OP_INTERRUPT_EXIT_OP);
  endproperty
  a_ien: assert property (p_ien)
    else $error("interrupt enable bit wrong after entry or exit");
  property p_keep;
    cur_op == OP_NOP && !mem_i.we |=>
      $stable(flag_word_o) && $stable(stack_ptr_o);
  endproperty
  a_keep: assert property (p_keep)
    else $error("flags or stack pointer changed on idle cycle");
  property p_sp_rd;
    mem_i.re && mem_i.addr == 16'h005D |=> mem_hit_o &&
      {8'h00, mem_rdata_o} == ($past(stack_ptr_o) & 16'h00FF);
  endproperty
  a_sp_rd: assert property (p_sp_rd)
    else $error("stack pointer low byte read wrong");
  property p_unmap;
    mem_i.re && mem_i.addr == 16'h0040 |=>
      !mem_hit_o && mem_rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read hit or gave data");
  c_push: cover property (cur_op == OP_PUSH);
  c_irq: cover property (cur_op == OP_IRQ);
  c_ptr: cover property (cur_op == OP_PTR_INC ##1 cur_op == OP_PTR_INC);
endmodule : cpu_regfile_flags_stack_chk

bind cpu_regfile_flags_stack cpu_regfile_flags_stack_chk u_chk (
  .core_clk_i (core_clk_i),
  .rst_n_i    (rst_n_i),
  .cmd_i      (cmd_i),
  .mem_i      (mem_i),
  .flag_word_o(flag_word_o),
  .stack_ptr_o(stack_ptr_o),
  .ptr_addr_o (ptr_addr_o),
  .mem_rdata_o(mem_rdata_o),
  .mem_hit_o  (mem_hit_o)
);

// ===== dv/cpu_regfile_flags_stack_bench.sv
/*
  Self-checking bench for the register file, flag and stack block.
  Assumes the checker binds itself; the bench drives all input ports.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module cpu_regfile_flags_stack_bench
  import cpu_core_pkg::*;
;
  logic        core_clk_i;
  logic        rst_n_i;
  cmd_t        cmd_i;
  mem_req_t    mem_i;
  logic [7:0]  flag_word_o;
  logic [15:0] stack_ptr_o;
  logic [15:0] ptr_addr_o;
  logic [7:0]  mem_rdata_o;
  logic        mem_hit_o;
  int          n_fail = 0;
  int          cmp_count = 0;
  logic [15:0] exp_sp;
  logic        exp_i;
  op_t         st_op [7] = '{OP_PUSH, OP_PUSH, OP_POP, OP_CALL, OP_IRQ,
                             OP_RET, OP_INTERRUPT_EXIT_OP};
  logic [15:0] st_dt [7] = '{16'hFFFF, 16'hFFFF, 16'h0001, 16'hFFFE,
                             16'hFFFE, 16'h0002, 16'h0002};

  cpu_regfile_flags_stack DUT (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .cmd_i      (cmd_i),
    .mem_i      (mem_i),
    .flag_word_o(flag_word_o),
    .stack_ptr_o(stack_ptr_o),
    .ptr_addr_o (ptr_addr_o),
    .mem_rdata_o(mem_rdata_o),
    .mem_hit_o  (mem_hit_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // One request per rising edge; results read 1 ns after the edge that takes it
  task automatic go(input cmd_t c, input mem_req_t m);
    cmd_i = c;
    mem_i = m;
    @(posedge core_clk_i);
    #1;
  endtask : go
  task automatic op(input op_t o, input logic [4:0] d, input logic [4:0] s,
                    input logic [7:0] i, input logic [2:0] b);
    go('{o, d, s, i, b}, '0);
  endtask : op
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    go('0, '{1'b1, 1'b0, a, v});
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e,
                    input logic eh, input string nm);
    go('0, '{1'b0, 1'b1, a, 8'h00});
    `CHK(nm, e, mem_rdata_o)
    `CHK("hit", eh, mem_hit_o)
  endtask : rd
  task automatic endt(input string nm);
    go('0, '0);
    $display("test %s done", nm);
  endtask : endt
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (3000) @(posedge core_clk_i);
    n_fail++;
    close_out();
  end

  initial begin
    rst_n_i = 1'b0;
    cmd_i = '0;
    mem_i = '0;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    `CHK("sp_rst", TOP_OF_DATA_MEMORY, stack_ptr_o)
    `CHK("flag_rst", FLAG_RESET, flag_word_o)
    rd(16'h005D, TOP_OF_DATA_MEMORY[7:0], 1'b1, "sp_lo");
    rd(16'h005E, TOP_OF_DATA_MEMORY[15:8], 1'b1, "sp_hi");
    rd(16'h0040, 8'h00, 1'b0, "unmapped");
    endt("reset");
    wr(16'h005E, 8'h04);
    wr(16'h005D, 8'h00);
    `CHK("sp_wr", 16'h0400, stack_ptr_o)
    op(OP_FSET, 5'h00, 5'h00, 8'h00, 3'h7);
    exp_i = 1'b1;
    exp_sp = 16'h0400;
    foreach (st_op[k]) begin
      op(st_op[k], 5'h00, 5'h00, 8'h00, 3'h0);
      exp_sp = exp_sp + st_dt[k];
      if (st_op[k] == OP_IRQ) exp_i = 1'b0;
      if (st_op[k] == OP_INTERRUPT_EXIT_OP) exp_i = 1'b1;
      `CHK("sp_step", exp_sp, stack_ptr_o)
      `CHK("i_bit", exp_i, flag_word_o[FLAG_I])
    end
    endt("stack");
    wr(16'h0001, 8'h7F);
    wr(16'h0002, 8'h01);
    op(OP_ADD, 5'h01, 5'h02, 8'h00, 3'h0);
    `CHK("add_f", 8'hAC, flag_word_o)
    op(OP_ADD, 5'h01, 5'h01, 8'h00, 3'h0);
    `CHK("add2_f", 8'h9B, flag_word_o)
    rd(16'h0001, 8'h00, 1'b1, "r1");
    wr(16'h0003, 8'h12);
    op(OP_MUL, 5'h03, 5'h03, 8'h00, 3'h0);
    op(OP_MOVW, 5'h08, 5'h00, 8'h00, 3'h0);
    rd(16'h0008, 8'h44, 1'b1, "movw_lo");
    rd(16'h0009, 8'h01, 1'b1, "movw_hi");
    endt("alu");
    for (int p = 0; p < 3; p++) begin
      wr(16'h001A + 16'(2 * p), 8'h20 + 8'(p));
      wr(16'h001B + 16'(2 * p), 8'(p));
      op(OP_PTR_DISP, 5'h00, 5'h00, 8'h03, 3'(p));
      `CHK("disp", {8'(p), 8'h23 + 8'(p)}, ptr_addr_o)
    end
    op(OP_PTR_INC, 5'h00, 5'h00, 8'h00, 3'h0);
    op(OP_PTR_INC, 5'h00, 5'h00, 8'h00, 3'h0);
    `CHK("inc", 16'h0021, ptr_addr_o)
    op(OP_PTR_DEC, 5'h00, 5'h00, 8'h00, 3'h0);
    `CHK("dec", 16'h0021, ptr_addr_o)
    rd(16'h001A, 8'h21, 1'b1, "ptr_lo");
    endt("pointers");
    wr(16'h005F, 8'h04);
    `CHK("sw_flags", 8'h14, flag_word_o)
    wr(16'h0003, 8'h08);
    op(OP_BST, 5'h03, 5'h00, 8'h00, 3'h3);
    `CHK("t_bit", 8'h54, flag_word_o)
    op(OP_FCLR, 5'h00, 5'h00, 8'h00, 3'h2);
    `CHK("fclr", 8'h40, flag_word_o)
    op(OP_BLD, 5'h0A, 5'h00, 8'h00, 3'h0);
    rd(16'h000A, 8'h01, 1'b1, "bld");
    endt("flags");
    op(OP_LDI, 5'h10, 5'h00, 8'h3A, 3'h0);
    op(OP_LDI, 5'h11, 5'h00, 8'h4B, 3'h0);
    op(OP_SUB, 5'h10, 5'h11, 8'h00, 3'h0);
    `CHK("sub_f", 8'h75, flag_word_o)
    op(OP_SBC, 5'h10, 5'h11, 8'h00, 3'h0);
    `CHK("sbc_f", 8'h54, flag_word_o)
    rd(16'h0010, 8'hA3, 1'b1, "sbc_r");
    op(OP_COM, 5'h10, 5'h00, 8'h00, 3'h0);
    `CHK("com_f", 8'h41, flag_word_o)
    op(OP_EOR, 5'h10, 5'h10, 8'h00, 3'h0);
    `CHK("eor_f", 8'h43, flag_word_o)
    op(OP_ADC, 5'h10, 5'h11, 8'h00, 3'h0);
    `CHK("adc_f", 8'h40, flag_word_o)
    rd(16'h0010, 8'h4C, 1'b1, "adc_r");
    op(OP_LDI, 5'h12, 5'h00, 8'h7F, 3'h0);
    op(OP_INC, 5'h12, 5'h00, 8'h00, 3'h0);
    `CHK("inc_f", 8'h4C, flag_word_o)
    op(OP_DEC, 5'h12, 5'h00, 8'h00, 3'h0);
    `CHK("dec_f", 8'h58, flag_word_o)
    op(OP_LDI, 5'h18, 5'h00, 8'hFF, 3'h0);
    op(OP_ADIW, 5'h18, 5'h00, 8'h01, 3'h0);
    rd(16'h0019, 8'h01, 1'b1, "adiw_hi");
    op(OP_SBIW, 5'h18, 5'h00, 8'h01, 3'h0);
    rd(16'h0018, 8'hFF, 1'b1, "sbiw_lo");
    op(OP_MOV, 5'h05, 5'h10, 8'h00, 3'h0);
    rd(16'h0005, 8'h4C, 1'b1, "mov");
    op(OP_AND, 5'h10, 5'h11, 8'h00, 3'h0);
    rd(16'h0010, 8'h48, 1'b1, "and_r");
    op(OP_OR, 5'h10, 5'h18, 8'h00, 3'h0);
    `CHK("or_f", 8'h54, flag_word_o)
    op(OP_FSET, 5'h00, 5'h00, 8'h00, 3'h1);
    `CHK("fset_z", 8'h56, flag_word_o)
    op(OP_FCLR, 5'h00, 5'h00, 8'h00, 3'h1);
    `CHK("fclr_z", 8'h54, flag_word_o)
    endt("alu2");
    rst_n_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    `CHK("sp_rst2", TOP_OF_DATA_MEMORY, stack_ptr_o)
    `CHK("flag_rst2", FLAG_RESET, flag_word_o)
    rd(16'h0008, 8'h00, 1'b1, "r8_rst");
    endt("reset2");
    close_out();
  end
endmodule : cpu_regfile_flags_stack_bench
